// [src/root_hub_desc_pkg.sv]
// root hub descriptor package: register offsets, field positions, resets,
// and the packed carrier for downstream port power commands.
// assumes a host register port with byte addresses and 32-bit words.
// Function
// [R1] The compound device flag always reads as zero.
// [R2] With no power switching clear ports are switched, with it set they are always on.
// [R3] The switching mode bit is ignored whenever no power switching is set.
// [R4] With switching mode zero all ports switch on and off together as one group.
// [R5] In individual mode a masked port obeys only per-port set and clear commands.
// [R6] In individual mode an unmasked port obeys only the global set and clear switch.
// [R7] The port count field reports the ports provided, between one and fifteen.
// [R8] The power control mask is bits 31 to 16, bit 0 reserved, bit n for port n.
// [R9] In global switching mode the power control mask has no effect on port power.
// [R10] The removable field is bits 15 to 0, bit n for port n, one meaning not removable.
// [R11] Host software programs mask and removable fields to match the real system.
// [R12] Set global power in per-port mode powers only unmasked ports; zero does nothing.
// [R13] Mask and removable bits above the implemented ports are stored but unused.
package root_hub_desc_pkg;

  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned NUM_PORTS       = 2;

  // byte offsets from the controller base address
  localparam logic [7:0]  OFFS_DESC_FIRST  = 8'h48;
  localparam logic [7:0]  OFFS_DESC_SECOND = 8'h4C;

  // first descriptor field positions
  localparam int unsigned POS_POWER_GOOD_LO = 24;
  localparam int unsigned POS_NO_OC_PROT    = 12;
  localparam int unsigned POS_OC_MODE       = 11;
  localparam int unsigned POS_COMPOUND      = 10;
  localparam int unsigned POS_NO_PWR_SW     = 9;
  localparam int unsigned POS_PWR_SW_MODE   = 8;
  localparam int unsigned POS_PORT_COUNT_LO = 0;

  // second descriptor field positions
  localparam int unsigned POS_MASK_LO      = 16;
  localparam int unsigned POS_REMOVABLE_LO = 0;

  // writable bits of the first descriptor: power good time, oc bits, nps, psm
  localparam logic [31:0] DESC_FIRST_WMASK = 32'hFF001B00;

  // reset values
  localparam logic [31:0] DESC_FIRST_RST   = 32'hFF000900;
  localparam logic [15:0] MASK_RST         = 16'h0002;
  localparam logic [15:0] REMOVABLE_RST    = 16'h0000;
  localparam logic [7:0]  PORT_COUNT       = 8'h02;
  localparam logic [31:0] RDATA_UNMAPPED   = 32'h00000000;

  // one cycle command strobes toward the port power switches
  typedef struct packed {
    logic                 set_global;
    logic                 clear_global;
    logic [NUM_PORTS-1:0] set_port;
    logic [NUM_PORTS-1:0] clear_port;
  } power_cmd_t;

endpackage

// [src/root_hub_port_power_descriptor.sv]
// root hub descriptor registers and the port power switch logic they steer.
// assumes synchronous register strobes and power command pulses, one clock.
`timescale 1ns/1ps

module root_hub_port_power_descriptor
  import root_hub_desc_pkg::*;
(
  input  wire logic                 sys_clk_in,
  input  wire logic                 arst_n_in,
  input  wire logic [ADDR_W-1:0]    reg_addr_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  input  wire logic [DATA_W-1:0]    reg_wdata_in,
  input  wire power_cmd_t           power_cmd_in,
  output logic      [DATA_W-1:0]    reg_rdata_out,
  output logic                      reg_rvalid_out,
  output logic      [NUM_PORTS-1:0] port_power_out,
  output logic      [NUM_PORTS-1:0] port_fixed_out
);

  // address decode shared by the read and write paths
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [7:0]        offs);
    addr_hit = (a == offs);
  endfunction

  // write strobe aimed at one register offset
  function automatic logic wr_hit(input logic              wr,
                                  input logic [ADDR_W-1:0] a,
                                  input logic [7:0]        offs);
    wr_hit = wr & addr_hit(a, offs);
  endfunction

  // read strobe aimed at one register offset
  function automatic logic rd_hit(input logic              rd,
                                  input logic [ADDR_W-1:0] a,
                                  input logic [7:0]        offs);
    rd_hit = rd & addr_hit(a, offs);
  endfunction

  // routes the command pulses to one port and returns {set, clear};
  // ganged mode lets a per-port command move the whole group, so
  // software can never split ports that share one supply switch
  function automatic logic [1:0] port_cmd(input logic        indiv,
                                          input logic        masked,
                                          input power_cmd_t  cmd,
                                          input int unsigned idx);
    logic set_sel;
    logic clr_sel;
    set_sel = 1'b0;
    clr_sel = 1'b0;
    if (indiv) begin
      // mask set: the port listens to its own commands only
      if (masked) begin
        set_sel = cmd.set_port[idx]; // [R5]
        clr_sel = cmd.clear_port[idx]; // [R5]
      end else begin
        // mask clear: the port follows the global switch only
        set_sel = cmd.set_global; // [R6] [R12]
        clr_sel = cmd.clear_global; // [R6]
      end
    end else begin
      set_sel = cmd.set_global | (|cmd.set_port); // [R4] [R9]
      clr_sel = cmd.clear_global | (|cmd.clear_port); // [R4] [R9]
    end
    port_cmd = {set_sel, clr_sel};
  endfunction

  // first descriptor, stored field by field; reserved bits have no
  // storage at all, so they always read back as zero
  logic [7:0]           power_good_reg;
  logic [7:0]           power_good_next;
  logic                 no_oc_prot_reg;
  logic                 no_oc_prot_next;
  logic                 oc_mode_reg;
  logic                 oc_mode_next;
  logic                 no_power_switching_reg;
  logic                 no_power_switching_next;
  logic                 power_switching_mode_reg;
  logic                 power_switching_mode_next;

  // second descriptor halves, all sixteen bits of each kept
  logic [15:0]          mask_reg;
  logic [15:0]          mask_next;
  logic [15:0]          removable_reg;
  logic [15:0]          removable_next;

  // read port
  logic [DATA_W-1:0]    rdata_reg;
  logic [DATA_W-1:0]    rdata_next;
  logic                 rvalid_reg;
  logic                 rvalid_next;

  // port switches and their removable copies
  logic [NUM_PORTS-1:0] power_reg;
  logic [NUM_PORTS-1:0] power_next;
  logic [NUM_PORTS-1:0] fixed_reg;
  logic [NUM_PORTS-1:0] fixed_next;
  logic [1:0]           port_sel [NUM_PORTS];
  logic [NUM_PORTS-1:0] port_set;
  logic [NUM_PORTS-1:0] port_clear;

  // decoded strobes, mode and read views
  logic                 first_wr;
  logic                 second_wr;
  logic                 first_rd;
  logic                 second_rd;
  logic                 no_power_switching;
  logic                 power_switching_mode;
  logic                 individual_mode;
  logic [31:0]          desc_first_view;
  logic [31:0]          desc_second_view;

  // strobes decoded once, shared by the next-state and read logic;
  // the address is compared whole, so aliases never hit
  assign first_wr  = wr_hit(reg_wr_in, reg_addr_in, OFFS_DESC_FIRST);
  assign second_wr = wr_hit(reg_wr_in, reg_addr_in, OFFS_DESC_SECOND);
  assign first_rd  = rd_hit(reg_rd_in, reg_addr_in, OFFS_DESC_FIRST);
  assign second_rd = rd_hit(reg_rd_in, reg_addr_in, OFFS_DESC_SECOND);

  // plain aliases of the stored mode bits
  assign no_power_switching   = no_power_switching_reg;
  assign power_switching_mode = power_switching_mode_reg;
  // the mode bit only counts while switching is supported; with
  // switching off every port is on anyway, so the bit is moot
  assign individual_mode = ~no_power_switching & power_switching_mode; // [R3]

  // first descriptor as read: compound flag low, port count fixed,
  // so software can never be told of a hub it does not have
  always_comb begin
    desc_first_view = '0;
    desc_first_view[POS_POWER_GOOD_LO +: 8] = power_good_reg;
    desc_first_view[POS_NO_OC_PROT]         = no_oc_prot_reg;
    desc_first_view[POS_OC_MODE]            = oc_mode_reg;
    desc_first_view[POS_COMPOUND]           = 1'b0; // [R1]
    desc_first_view[POS_NO_PWR_SW]          = no_power_switching_reg;
    desc_first_view[POS_PWR_SW_MODE]        = power_switching_mode_reg;
    desc_first_view[POS_PORT_COUNT_LO +: 8] = PORT_COUNT; // [R7]
  end

  // second descriptor reads back as stored, high bits included,
  // so software can check what it programmed
  always_comb begin
    desc_second_view = '0;
    desc_second_view[POS_MASK_LO +: 16]      = mask_reg; // [R8]
    desc_second_view[POS_REMOVABLE_LO +: 16] = removable_reg; // [R10]
  end

  // first descriptor writes; the compound flag and port count have
  // no storage, so writes to them are simply dropped
  always_comb begin
    power_good_next           = power_good_reg;
    no_oc_prot_next           = no_oc_prot_reg;
    oc_mode_next              = oc_mode_reg;
    no_power_switching_next   = no_power_switching_reg;
    power_switching_mode_next = power_switching_mode_reg;
    if (first_wr) begin
      power_good_next           = reg_wdata_in[POS_POWER_GOOD_LO +: 8];
      no_oc_prot_next           = reg_wdata_in[POS_NO_OC_PROT];
      oc_mode_next              = reg_wdata_in[POS_OC_MODE];
      no_power_switching_next   = reg_wdata_in[POS_NO_PWR_SW]; // [R2]
      power_switching_mode_next = reg_wdata_in[POS_PWR_SW_MODE]; // [R3]
    end
  end

  // second descriptor writes; bits above the two ports are kept
  // as storage only and steer nothing
  always_comb begin
    mask_next      = mask_reg;
    removable_next = removable_reg;
    if (second_wr) begin
      mask_next      = reg_wdata_in[POS_MASK_LO +: 16]; // [R8] [R13]
      removable_next = reg_wdata_in[POS_REMOVABLE_LO +: 16]; // [R10] [R13]
    end
  end

  // read path: one cycle latency, data holds until the next read;
  // unmapped offsets answer zero rather than stale data
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = reg_rd_in;
    if (reg_rd_in) begin
      if (first_rd) begin
        rdata_next = desc_first_view;
      end else if (second_rd) begin
        rdata_next = desc_second_view;
      end else begin
        rdata_next = RDATA_UNMAPPED;
      end
    end
  end

  // one router per port; mask bit 0 is reserved, so port n reads
  // mask bit n and port index p sits one place lower
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p++) begin : g_port
      assign port_sel[p] = port_cmd(individual_mode,
                                    mask_reg[p+1], // [R8]
                                    power_cmd_in,
                                    p);
    end
  endgenerate

  // set and clear requests per port, gathered into two vectors
  // so that the switch logic reads like the rules
  always_comb begin
    for (int unsigned j = 0; j < NUM_PORTS; j++) begin
      port_set[j]   = port_sel[j][1];
      port_clear[j] = port_sel[j][0];
    end
  end

  // power switch next state; set wins over a clear in the same
  // cycle, so a racing pair never leaves a port dark
  always_comb begin
    power_next = power_reg;
    for (int unsigned i = 0; i < NUM_PORTS; i++) begin
      // switching off: the supply is treated as hard wired on
      if (no_power_switching) begin
        power_next[i] = 1'b1; // [R2]
      end else if (port_set[i]) begin
        power_next[i] = 1'b1; // [R2]
      end else if (port_clear[i]) begin
        power_next[i] = 1'b0;
      end else begin
        power_next[i] = power_reg[i];
      end
    end
  end

  // removable copy per port; bit 0 is reserved and bits above
  // the implemented ports go nowhere
  always_comb begin
    fixed_next = removable_reg[NUM_PORTS:1]; // [R10] [R13]
  end

  // first descriptor storage; reset values come from one packed
  // constant so the read view and reset can never drift apart
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      power_good_reg           <= DESC_FIRST_RST[POS_POWER_GOOD_LO +: 8];
      no_oc_prot_reg           <= DESC_FIRST_RST[POS_NO_OC_PROT];
      oc_mode_reg              <= DESC_FIRST_RST[POS_OC_MODE];
      no_power_switching_reg   <= DESC_FIRST_RST[POS_NO_PWR_SW];
      power_switching_mode_reg <= DESC_FIRST_RST[POS_PWR_SW_MODE];
    end else begin
      power_good_reg           <= power_good_next;
      no_oc_prot_reg           <= no_oc_prot_next;
      oc_mode_reg              <= oc_mode_next;
      no_power_switching_reg   <= no_power_switching_next;
      power_switching_mode_reg <= power_switching_mode_next;
    end
  end

  // second descriptor storage; port 1 comes up masked, so it
  // ignores the global switch until software says otherwise
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mask_reg      <= MASK_RST;
      removable_reg <= REMOVABLE_RST;
    end else begin
      mask_reg      <= mask_next;
      removable_reg <= removable_next;
    end
  end

  // read port registers; rvalid is a one cycle pulse, the data
  // register is what keeps the answer standing
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_reg  <= RDATA_UNMAPPED;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // port switches start off; nothing is powered until the mode
  // or a command turns it on
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      power_reg <= '0;
    end else begin
      power_reg <= power_next;
    end
  end

  // removable copies, one clock behind the stored flags so the
  // output comes straight from a flip-flop
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      fixed_reg <= '0;
    end else begin
      fixed_reg <= fixed_next;
    end
  end

  // every output straight from its flip-flop, no logic after it
  // so the far side sees clean levels
  assign reg_rdata_out  = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;
  assign port_power_out = power_reg;
  assign port_fixed_out = fixed_reg;

endmodule // root_hub_port_power_descriptor

// [testbench/rh_power_chk.sv]
// assertions on the descriptor reads and the port power outputs
// assumes a bind onto the descriptor block, seeing only its ports
`timescale 1ns/1ps
module rh_power_chk
  import root_hub_desc_pkg::*;
(
  input wire logic              sys_clk_in,
  input wire logic              arst_n_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic              reg_wr_in,
  input wire logic              reg_rd_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire power_cmd_t        power_cmd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  input wire logic              reg_rvalid_out,
  input wire logic [1:0]        port_power_out,
  input wire logic [1:0]        port_fixed_out
);
  logic [1:0] md; // shadow of no switching and mode bits
  logic [2:1] mk; // shadow of mask bits for ports 1 and 2
  logic       pp;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);
  // shadows follow writes, so mode checks need no hierarchy peeking
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      md <= 2'h1;
      mk <= 2'h1;
    end else if (reg_wr_in && reg_addr_in == OFFS_DESC_FIRST) begin
      md <= reg_wdata_in[9:8];
    end else if (reg_wr_in && reg_addr_in == OFFS_DESC_SECOND) begin
      mk <= reg_wdata_in[18:17];
    end
  end
  assign pp = !md[1] && md[0];
  sequence rd_first;
    reg_rd_in && reg_addr_in == OFFS_DESC_FIRST;
  endsequence
  compound_zero_a: assert property (rd_first |=> !reg_rdata_out[10])
    else $error("compound flag read as one");
  port_count_a: assert property (rd_first |=> reg_rdata_out[7:0] == 8'h02)
    else $error("wrong port count");
  always_on_a: assert property (md[1] |=> port_power_out == 2'h3)
    else $error("ports not forced on");
  ganged_set_a: assert property (md == 2'h0 && power_cmd_in.set_global
    |=> port_power_out == 2'h3) else $error("ganged set failed");
  ganged_clr_a: assert property (md == 2'h0 && power_cmd_in == 6'h10
    |=> port_power_out == 2'h0) else $error("ganged clear failed");
  masked_port_a: assert property (pp && mk[1] && power_cmd_in[2] == 1'h0
    && power_cmd_in[0] == 1'h0 |=> $stable(port_power_out[0]))
    else $error("masked port moved");
  unmasked_port_a: assert property (pp && !mk[2]
    && power_cmd_in[5:4] == 2'h0 |=> $stable(port_power_out[1]))
    else $error("unmasked port moved");
  global_set_a: assert property (pp && !mk[2] && power_cmd_in.set_global
    |=> port_power_out[1]) else $error("global set missed port");
endmodule // rh_power_chk
bind root_hub_port_power_descriptor rh_power_chk i_rh_power_chk (
  .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
  .power_cmd_in(power_cmd_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .port_power_out(port_power_out),
  .port_fixed_out(port_fixed_out));

// [testbench/port_load_model.sv]
// downstream devices: each wakes one clock after its port gets power
// assumes the clock of the block under test
`timescale 1ns/1ps
module port_load_model (
  input  wire logic       clk_in,
  input  wire logic [1:0] power_in,
  output logic      [1:0] up_out
);
  // a device cannot answer before its supply settles
  always_ff @(posedge clk_in) up_out <= power_in;
endmodule // port_load_model

// [testbench/root_hub_port_power_descriptor_test.sv]
// bench for descriptor registers and port power switching
// assumes package, load model and checker compile first
`timescale 1ns/1ps
module root_hub_port_power_descriptor_test;
  import root_hub_desc_pkg::*;
  logic        clk, rst_n, wr, rd, rv;
  logic [7:0]  a;
  logic [31:0] wd, rdat;
  logic [1:0]  pw, fx, up;
  power_cmd_t  c;
  int          errors, checks_done;
  root_hub_port_power_descriptor i_root_hub_port_power_descriptor (
    .sys_clk_in(clk), .arst_n_in(rst_n), .reg_addr_in(a), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wd), .power_cmd_in(c),
    .reg_rdata_out(rdat), .reg_rvalid_out(rv), .port_power_out(pw),
    .port_fixed_out(fx));
  port_load_model i_port_load_model (.clk_in(clk), .power_in(pw), .up_out(up));
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk) #1 {a, wd, wr} = {ad, d, 1'h1};
    @(posedge clk) #1 wr = 1'h0;
  endtask
  task automatic rreg(input logic [7:0] ad, input logic [31:0] e);
    int n;
    @(posedge clk) #1 {a, rd} = {ad, 1'h1};
    @(posedge clk) #1 rd = 1'h0;
    for (n = 0; n < 4 && rv !== 1'h1; n++) @(posedge clk) #1;
    if (n == 4) begin
      chk(32'h1, 32'h0); // read never answered, counted as a mismatch
    end else begin
      chk(rdat, e);
    end
  endtask
  // one command pulse, then power must have settled
  task automatic pulse(input power_cmd_t p, input logic [1:0] e);
    @(posedge clk) #1 c = p;
    @(posedge clk) #1 c = '0;
    chk({30'h0, pw}, {30'h0, e});
  endtask
  task automatic t_always_on();
    wreg(OFFS_DESC_FIRST, 32'hFFFFFFFF);
    rreg(OFFS_DESC_FIRST, 32'hFF001B02);
    pulse(6'h10, 2'h3);
    pulse(6'h03, 2'h3);
    $display("t_always_on done");
  endtask
  task automatic t_ganged();
    wreg(OFFS_DESC_FIRST, 32'h0);
    pulse(6'h10, 2'h0);
    pulse(6'h04, 2'h3);
    pulse(6'h02, 2'h0);
    $display("t_ganged done");
  endtask
  task automatic t_per_port();
    wreg(OFFS_DESC_FIRST, 32'h100);
    wreg(OFFS_DESC_SECOND, 32'hFFFA0006);
    rreg(OFFS_DESC_SECOND, 32'hFFFA0006);
    chk({30'h0, fx}, 32'h3);
    pulse(6'h20, 2'h2);
    pulse(6'h04, 2'h3);
    pulse(6'h10, 2'h1);
    pulse(6'h02, 2'h1);
    @(posedge clk) #1 chk({30'h0, up}, 32'h1);
    $display("t_per_port done");
  endtask
  // free running 125 MHz clock
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst_n, wr, rd, a, wd, c} = '0;
    errors = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'h1;
    rreg(OFFS_DESC_FIRST, 32'hFF000902);
    rreg(OFFS_DESC_SECOND, 32'h00020000);
    rreg(8'h50, 32'h0);
    t_always_on();
    t_ganged();
    t_per_port();
    end_sim();
  end
endmodule // root_hub_port_power_descriptor_test
